// [accumulator_clear_load_ops.sv]
// What this block does
// - The in-place xor combines the memory word with the long immediate if given, else with the bit-manipulation mask register.
// - The in-place xor writes its result back to the address it read and leaves the accumulator alone.
// - The accumulator-zero operation clears every accumulator bit.
// - The high-load operation clears the low accumulator half and loads the memory word into the high half.
// - The rounded high-load loads the high half, clears bits 0 to 14 and sets bit 15.
// - The unsigned low-load puts the memory word in the low half and zeroes the high half without sign extension.
// - The combined-zero operation clears both accumulator and product register at once.
// - The product-zero operation clears the product register and leaves the accumulator alone.
`timescale 1ns/1ns
`default_nettype none

module accumulator_clear_load_ops
  import acc_ops_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              exec_valid,
  input  wire acc_op_e           exec_op,
  input  wire logic [WORD_W-1:0] mem_rdata,
  input  wire logic [WORD_W-1:0] mem_addr,
  input  wire logic [WORD_W-1:0] long_imm,
  input  wire logic              long_imm_valid,
  input  wire logic [WORD_W-1:0] bit_manip_mask_reg,
  output logic      [ACC_W-1:0]  acc,
  output logic      [ACC_W-1:0]  product,
  output logic                   mem_we,
  output logic      [WORD_W-1:0] mem_waddr,
  output logic      [WORD_W-1:0] mem_wdata
);

  // ==========================================================================
  // xor datapath
  logic [WORD_W-1:0] xor_result;

  acc_word_xor u_xor (
    .mem_word           (mem_rdata),
    .long_imm           (long_imm),
    .long_imm_valid     (long_imm_valid),
    .bit_manip_mask_reg (bit_manip_mask_reg),
    .xor_result         (xor_result)
  );

  // ==========================================================================
  // op decode
  // one strobe per op, so each register group below only asks whether it is
  // concerned; an idle cycle, op_none or an illegal code raises none of them,
  // which keeps a refused op from touching any state
  logic do_xor;
  logic do_acc_zero;
  logic do_high_load;
  logic do_high_round;
  logic do_low_load;
  logic do_both_zero;
  logic do_prod_zero;

  always_comb begin
    do_xor        = 1'b0;
    do_acc_zero   = 1'b0;
    do_high_load  = 1'b0;
    do_high_round = 1'b0;
    do_low_load   = 1'b0;
    do_both_zero  = 1'b0;
    do_prod_zero  = 1'b0;

    if (exec_valid) begin
      unique case (exec_op)
        op_none: begin
        end
        memory_xor_in_place: begin
          do_xor = 1'b1;
        end
        acc_zero_op: begin
          do_acc_zero = 1'b1;
        end
        acc_high_load_op: begin
          do_high_load = 1'b1;
        end
        acc_high_load_round_op: begin
          do_high_round = 1'b1;
        end
        acc_low_load_unsigned_op: begin
          do_low_load = 1'b1;
        end
        acc_and_product_zero_op: begin
          do_both_zero = 1'b1;
        end
        product_zero_op: begin
          do_prod_zero = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // accumulator load patterns
  // built apart from the select so each pattern reads like its rule
  logic [ACC_W-1:0] high_load_value;
  logic [ACC_W-1:0] high_round_value;
  logic [ACC_W-1:0] low_load_value;

  assign high_load_value  = {mem_rdata, HALF_ZERO};
  assign high_round_value = {mem_rdata, ROUND_LOW};
  assign low_load_value   = {HALF_ZERO, mem_rdata};

  // ==========================================================================
  // accumulator
  logic [ACC_W-1:0] next_acc;

  always_comb begin
    next_acc = acc;
    // decode raises at most one strobe, so the order below never matters

    if (do_acc_zero) begin
      next_acc = ACC_ZERO;
    end

    if (do_high_load) begin
      next_acc = high_load_value;
    end

    if (do_high_round) begin
      next_acc = high_round_value;
    end

    if (do_low_load) begin
      next_acc = low_load_value;
    end

    if (do_both_zero) begin
      next_acc = ACC_ZERO;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      acc <= ACC_ZERO;
    end else begin
      acc <= next_acc;
    end
  end

  // ==========================================================================
  // product register
  // only ever cleared here; no input of this block loads it, so it stays zero after reset
  logic [ACC_W-1:0] next_product;

  always_comb begin
    next_product = product;

    if (do_both_zero) begin
      next_product = PROD_ZERO;
    end

    if (do_prod_zero) begin
      next_product = PROD_ZERO;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      product <= PROD_ZERO;
    end else begin
      product <= next_product;
    end
  end

  // ==========================================================================
  // memory write port
  // only the xor writes memory; every other op leaves the port idle
  logic              next_mem_we;
  logic [WORD_W-1:0] next_mem_waddr;
  logic [WORD_W-1:0] next_mem_wdata;

  always_comb begin
    next_mem_we    = 1'b0;
    // hold address and data so a slow memory sees stable values after the strobe
    next_mem_waddr = mem_waddr;
    next_mem_wdata = mem_wdata;
    if (do_xor) begin
      next_mem_we    = 1'b1;
      next_mem_waddr = mem_addr;
      next_mem_wdata = xor_result;
    end
  end

  // the strobe is registered, so the write lands one cycle after execute;
  // reset is asynchronous, so a pending strobe drops at once
  // single-edge update
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mem_we    <= 1'b0;
      mem_waddr <= WORD_ZERO;
      mem_wdata <= WORD_ZERO;
    end else begin
      mem_we    <= next_mem_we;
      mem_waddr <= next_mem_waddr;
      mem_wdata <= next_mem_wdata;
    end
  end

endmodule

`default_nettype wire

// [acc_ops_pkg.sv]
`default_nettype none

package acc_ops_pkg;

  // ==========================================================================
  // widths
  localparam int ACC_W  = 32;
  localparam int WORD_W = 16;
  localparam int HALF_W = 16;

  // ==========================================================================
  // constants
  localparam logic [ACC_W-1:0]  ACC_ZERO      = 32'h0000_0000;
  localparam logic [ACC_W-1:0]  PROD_ZERO     = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_ZERO     = 16'h0000;
  localparam logic [HALF_W-1:0] HALF_ZERO     = 16'h0000;
  // half-lsb rounding pattern: bit 15 set, bits 0..14 clear
  localparam logic [HALF_W-1:0] ROUND_LOW     = 16'h8000;

  // ==========================================================================
  // operation codes
  typedef enum logic [3:0] {
    op_none,
    memory_xor_in_place,
    acc_zero_op,
    acc_high_load_op,
    acc_high_load_round_op,
    acc_low_load_unsigned_op,
    acc_and_product_zero_op,
    product_zero_op
  } acc_op_e;

endpackage

`default_nettype wire

// [acc_word_xor.sv]
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// xor source select and combine
module acc_word_xor
  import acc_ops_pkg::*;
(
  input  wire logic [WORD_W-1:0] mem_word,
  input  wire logic [WORD_W-1:0] long_imm,
  input  wire logic              long_imm_valid,
  input  wire logic [WORD_W-1:0] bit_manip_mask_reg,
  output logic      [WORD_W-1:0] xor_result
);

  always_comb begin
    if (long_imm_valid) begin
      xor_result = mem_word ^ long_imm;
    end else begin
      xor_result = mem_word ^ bit_manip_mask_reg;
    end
  end

endmodule

`default_nettype wire

// [acc_ops_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
// ====================
// checker
module acc_ops_asserts
  import acc_ops_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              exec_valid,
  input wire acc_op_e           exec_op,
  input wire logic [WORD_W-1:0] mem_rdata,
  input wire logic [WORD_W-1:0] mem_addr,
  input wire logic [WORD_W-1:0] long_imm,
  input wire logic              long_imm_valid,
  input wire logic [WORD_W-1:0] bit_manip_mask_reg,
  input wire logic [ACC_W-1:0]  acc,
  input wire logic [ACC_W-1:0]  product,
  input wire logic              mem_we,
  input wire logic [WORD_W-1:0] mem_waddr,
  input wire logic [WORD_W-1:0] mem_wdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [WORD_W-1:0] xs;
  assign xs = long_imm_valid ? long_imm : bit_manip_mask_reg;
  xor_data_a: assert property (exec_valid && exec_op == memory_xor_in_place
    |=> mem_wdata == $past(mem_rdata) ^ $past(xs)) else $error("xor data wrong");
  xor_wback_a: assert property (exec_valid && exec_op == memory_xor_in_place
    |=> mem_we && mem_waddr == $past(mem_addr) && $stable(acc)) else $error("xor writeback wrong");
  acc_zero_a: assert property (exec_valid && exec_op == acc_zero_op
    |=> acc == 32'h0000_0000) else $error("acc not zeroed");
  high_load_a: assert property (exec_valid && exec_op == acc_high_load_op
    |=> acc == {$past(mem_rdata), 16'h0000}) else $error("high load wrong");
  high_round_a: assert property (exec_valid && exec_op == acc_high_load_round_op
    |=> acc == {$past(mem_rdata), 16'h8000}) else $error("round load wrong");
  low_load_a: assert property (exec_valid && exec_op == acc_low_load_unsigned_op
    |=> acc == {16'h0000, $past(mem_rdata)}) else $error("low load wrong");
  both_zero_a: assert property (exec_valid && exec_op == acc_and_product_zero_op
    |=> acc == 32'h0000_0000 && product == 32'h0000_0000) else $error("both zero wrong");
  prod_zero_a: assert property (exec_valid && exec_op == product_zero_op
    |=> product == 32'h0000_0000 && $stable(acc)) else $error("product zero wrong");
  idle_hold_a: assert property (!exec_valid
    |=> !mem_we && $stable(acc) && $stable(product)) else $error("idle changed state");
  none_hold_a: assert property (exec_valid && exec_op == op_none
    |=> !mem_we && $stable(acc) && $stable(product)) else $error("no-op changed state");
  write_pulse_a: assert property (!(exec_valid && exec_op == memory_xor_in_place)
    |=> !mem_we) else $error("write strobe without xor");
  port_hold_a: assert property (!(exec_valid && exec_op == memory_xor_in_place)
    |=> $stable(mem_waddr) && $stable(mem_wdata)) else $error("write port moved without xor");
  cover property (exec_valid && exec_op == memory_xor_in_place && long_imm_valid);
  cover property (exec_valid && exec_op == acc_high_load_round_op);
  cover property (exec_valid && exec_op == acc_and_product_zero_op);
  cover property (exec_valid && exec_op == memory_xor_in_place && !long_imm_valid);
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ns
`default_nettype none
// ====================
// random op stream against a model
module testbench
  import acc_ops_pkg::*;
;
  logic        mclk, reset, exec_valid, long_imm_valid, mem_we, wem;
  acc_op_e     exec_op;
  logic [15:0] mem_rdata, mem_addr, long_imm, bit_manip_mask_reg;
  logic [15:0] mem_waddr, mem_wdata, wam, wdm, xs;
  logic [31:0] acc, product, r, am, pm;
  int          fail_count = 0, n_checks = 0;
  accumulator_clear_load_ops dut (.mclk, .reset, .exec_valid, .exec_op, .mem_rdata, .mem_addr,
    .long_imm, .long_imm_valid, .bit_manip_mask_reg, .acc, .product, .mem_we, .mem_waddr,
    .mem_wdata);
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp_acc(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected acc t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_product(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected product t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_strobe(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected write strobe t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_word(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected write word t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // address and data are held between writes, so they are compared every cycle
  task automatic check_all;
    cmp_acc(acc, am);
    cmp_product(product, pm);
    cmp_strobe(mem_we, wem);
    cmp_word(mem_wdata, wdm);
    cmp_word(mem_waddr, wam);
  endtask
  task automatic drive_random;
    r = nx(nx(r));
    exec_valid = r[0] | r[1];
    exec_op = acc_op_e'(r[4:2]);
    {long_imm_valid, mem_rdata, long_imm} = {r[5], r[31:16], r[21:6]};
    {mem_addr, bit_manip_mask_reg} = {r[15:0] ^ 16'hA5A5, ~r[27:12]};
    xs = long_imm_valid ? long_imm : bit_manip_mask_reg;
    wem = 1'b0;
    if (exec_valid) begin
      case (exec_op)
        memory_xor_in_place: {wem, wam, wdm} = {1'b1, mem_addr, mem_rdata ^ xs};
        acc_zero_op: am = 32'h0000_0000;
        acc_high_load_op: am = {mem_rdata, 16'h0000};
        acc_high_load_round_op: am = {mem_rdata, 16'h8000};
        acc_low_load_unsigned_op: am = {16'h0000, mem_rdata};
        acc_and_product_zero_op: {am, pm} = 64'h0;
        product_zero_op: pm = 32'h0000_0000;
        default: ;
      endcase
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // hang guard, run needs about 31 us
  initial begin
    #60000;
    fail_count++;
    test_done;
  end
  initial begin
    {reset, exec_valid, long_imm_valid, wem} = 4'h8;
    exec_op = op_none;
    {mem_rdata, mem_addr, long_imm, bit_manip_mask_reg, wam, wdm} = 96'h0;
    {am, pm} = 64'h0;
    r = 82586;
    repeat (20) @(posedge mclk);
    #5 reset = 1'b0;
    repeat (300) begin
      @(posedge mclk);
      #5;
      check_all;
      drive_random;
    end
    @(posedge mclk);
    #5;
    check_all;
    // mid-run reset: every output clears at once, before any clock edge
    reset = 1'b1;
    exec_valid = 1'b0;
    {am, pm} = 64'h0;
    {wam, wdm} = 32'h0;
    wem = 1'b0;
    #1;
    check_all;
    repeat (2) @(posedge mclk);
    #5 reset = 1'b0;
    repeat (300) begin
      @(posedge mclk);
      #5;
      check_all;
      drive_random;
    end
    @(posedge mclk);
    #5;
    check_all;
    test_done;
  end
endmodule
bind accumulator_clear_load_ops acc_ops_asserts u_chk (.mclk, .reset, .exec_valid, .exec_op,
  .mem_rdata, .mem_addr, .long_imm, .long_imm_valid, .bit_manip_mask_reg, .acc, .product,
  .mem_we, .mem_waddr, .mem_wdata);
`default_nettype wire
